// ---- rtl/brp_params.svh ----
// register map, field positions and reset values of the block ram port control
`ifndef BRP_PARAMS_SVH
`define BRP_PARAMS_SVH
// ----------------------------------------
// apb register byte addresses
// ----------------------------------------
`define BRP_ADDR_CTRL 12'h000
`define BRP_ADDR_CFG_A 12'h004
`define BRP_ADDR_CFG_B 12'h008
`define BRP_ADDR_STATUS 12'h00c
`define BRP_ADDR_LOAD_ADDR 12'h010
`define BRP_ADDR_LOAD_LO 12'h014
`define BRP_ADDR_LOAD_HI 12'h018
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define BRP_CTRL_WREN 0
`define BRP_CTRL_MODE 2:1
`define BRP_CTRL_RST 3'h3
`define BRP_CFG_WSEL 2:0
`define BRP_CFG_WMODE 4:3
`define BRP_CFG_OREG 5
`define BRP_CFG_RST 6'h04
`define BRP_ST_CFG_ERR 0
`define BRP_ST_A_CLR 1
`define BRP_ST_B_CLR 2
`define BRP_ST_CHIP_CLR 3
`define BRP_LOAD_HI 3:0
// width select codes
`define BRP_WSEL_X1 3'h0
`define BRP_WSEL_X2 3'h1
`define BRP_WSEL_X4 3'h2
`define BRP_WSEL_X9 3'h3
`define BRP_WSEL_X18 3'h4
`define BRP_WSEL_X36 3'h5
`endif

// ---- rtl/brp_pkg.sv ----
// types and word mapping functions of the block ram port control
`include "brp_params.svh"
package brp_pkg;
	typedef logic [12:0] brp_addr_t;
	typedef logic [35:0] brp_data_t;
	typedef logic [7:0] brp_widx_t;
	typedef logic [5:0] brp_off_t;
	typedef logic [2:0] brp_wsel_t;
	typedef enum logic [1:0] {BRP_WM_NORMAL, BRP_WM_THRU, BRP_WM_RBW, BRP_WM_RSVD} brp_wmode_t;
	typedef enum logic [1:0] {BRP_SINGLE, BRP_TRUE_DUAL, BRP_PSEUDO_DUAL, BRP_MODE_RSVD} brp_pmode_t;

	// data mask for a width select
	function automatic brp_data_t brp_mask(input brp_wsel_t s);
		case (s)
			`BRP_WSEL_X1: brp_mask = 36'h000000001;
			`BRP_WSEL_X2: brp_mask = 36'h000000003;
			`BRP_WSEL_X4: brp_mask = 36'h00000000f;
			`BRP_WSEL_X9: brp_mask = 36'h0000001ff;
			`BRP_WSEL_X18: brp_mask = 36'h00003ffff;
			default: brp_mask = 36'hfffffffff;
		endcase
	endfunction : brp_mask

	// 36-bit array word holding a port address
	function automatic brp_widx_t brp_word(input brp_wsel_t s, input brp_addr_t a);
		case (s)
			`BRP_WSEL_X1: brp_word = a[12:5];
			`BRP_WSEL_X2: brp_word = a[11:4];
			`BRP_WSEL_X4: brp_word = a[10:3];
			`BRP_WSEL_X9: brp_word = a[9:2];
			`BRP_WSEL_X18: brp_word = a[8:1];
			default: brp_word = a[7:0];
		endcase
	endfunction : brp_word

	// bit offset inside the word, lsb of word 0 first
	function automatic brp_off_t brp_off(input brp_wsel_t s, input brp_addr_t a);
		case (s)
			`BRP_WSEL_X1: brp_off = {1'b0, a[4:0]};
			`BRP_WSEL_X2: brp_off = {1'b0, a[3:0], 1'b0};
			`BRP_WSEL_X4: brp_off = {1'b0, a[2:0], 2'b00};
			`BRP_WSEL_X9: brp_off = {1'b0, a[1:0], 3'b000} + {4'h0, a[1:0]};
			`BRP_WSEL_X18: brp_off = a[0] ? 6'h12 : 6'h00;
			default: brp_off = 6'h00;
		endcase
	endfunction : brp_off
endpackage : brp_pkg

// ---- rtl/brp_port_if.sv ----
// signals between the array control and one port read path
`timescale 1ns/100ps
interface brp_port_if;
	import brp_pkg::*;
	logic req;
	logic wr;
	logic ce;
	logic oreg;
	logic clr;
	brp_wmode_t wmode;
	brp_data_t wdata;
	brp_data_t rdarr;
	brp_data_t dout;
	modport ctl (output req, wr, ce, oreg, clr, wmode, wdata, rdarr, input dout);
	modport port (input req, wr, ce, oreg, clr, wmode, wdata, rdarr, output dout);
endinterface : brp_port_if

// ---- rtl/brp_port_out.sv ----
// read path of one port: output latch, write behaviour and optional output register
`timescale 1ns/100ps
module brp_port_out (
	// clock and synchronous reset
	input wire logic clk,
	input wire logic rst,
	// port link
	brp_port_if.port pif
);
	import brp_pkg::*;
	brp_data_t latch_q;
	brp_data_t latch_d;
	brp_data_t out_q;

	// ----------------------------------------
	// output latch
	// ----------------------------------------
	// next latch value by cycle kind and write behaviour
	always_comb begin
		latch_d = latch_q;
		if (pif.req) begin
			if (!pif.wr) begin
				latch_d = pif.rdarr;
			end else begin
				case (pif.wmode)
					BRP_WM_THRU: latch_d = pif.wdata;
					BRP_WM_RBW: latch_d = pif.rdarr;
					default: latch_d = latch_q;
				endcase
			end
		end
	end

	// latch clears at once on a port or chip-wide reset
	always_ff @(posedge clk or posedge pif.clr) begin
		if (pif.clr) begin
			latch_q <= 36'h000000000;
		end else if (rst) begin
			latch_q <= 36'h000000000;
		end else begin
			latch_q <= latch_d;
		end
	end

	// output stage: extra register or same-edge bypass
	always_ff @(posedge clk or posedge pif.clr) begin
		if (pif.clr) begin
			out_q <= 36'h000000000;
		end else if (rst) begin
			out_q <= 36'h000000000;
		end else if (pif.oreg) begin
			if (pif.ce) begin
				out_q <= latch_q;
			end
		end else begin
			out_q <= latch_d;
		end
	end
	assign pif.dout = out_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_oreg_stage: assert property (@(posedge clk) disable iff (rst || pif.clr)
		pif.oreg && pif.ce |=> out_q == $past(latch_q)) else $error("output register stage wrong");
	a_bypass_read: assert property (@(posedge clk) disable iff (rst || pif.clr)
		!pif.oreg && pif.req && !pif.wr |=> out_q == $past(pif.rdarr)) else $error("bypass read wrong");
	a_normal_hold: assert property (@(posedge clk) disable iff (rst || pif.clr)
		!pif.oreg && pif.req && pif.wr && pif.wmode == BRP_WM_NORMAL |=> $stable(out_q))
		else $error("normal write reached output");
	a_write_thru: assert property (@(posedge clk) disable iff (rst || pif.clr)
		!pif.oreg && pif.req && pif.wr && pif.wmode == BRP_WM_THRU |=> out_q == $past(pif.wdata))
		else $error("write-through data missing");
	a_rbw_old: assert property (@(posedge clk) disable iff (rst || pif.clr)
		!pif.oreg && pif.req && pif.wr && pif.wmode == BRP_WM_RBW |=> out_q == $past(pif.rdarr))
		else $error("old contents not shown");
	a_sync_clear: assert property (@(posedge clk) disable iff (pif.clr)
		rst |=> latch_q == 36'h000000000 && out_q == 36'h000000000) else $error("sync reset missed");
	c_thru: cover property (@(posedge clk) pif.req && pif.wr && pif.wmode == BRP_WM_THRU);
	c_rbw: cover property (@(posedge clk) pif.req && pif.wr && pif.wmode == BRP_WM_RBW);
	c_oreg_read: cover property (@(posedge clk) pif.oreg && pif.req && !pif.wr ##1 pif.ce);
endmodule : brp_port_out

// ---- rtl/brp_ram_ctl.sv ----
// dual-port block ram with registered inputs, port read paths and an apb register file
//
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "brp_params.svh"

// Behaviour
// - address and write data registered before array
// - per-port optional output register stage
// - normal mode: writes never reach output
// - write-through copies write data to output
// - read-before-write shows old word, x9/x18/x36
// - local reset clears own port latches asynchronously
// - chip-wide reset clears both ports together
// - chip-wide reset acts without the clock
// - synchronous reset needs no enable sequencing
// - widths x1 to x36, true dual x18 max
// - narrow words packed lsb first per port
// - preload allowed, writes disabled acts rom
module brp_ram_ctl (
	// clock and synchronous reset
	input wire logic CLOCK,
	input wire logic RST,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// asynchronous output resets
	input wire logic PORT_A_OUTPUT_RESET,
	input wire logic PORT_B_OUTPUT_RESET,
	input wire logic CHIP_WIDE_RESET_N,
	// port a
	input wire logic A_CE,
	input wire logic A_WE,
	input wire brp_pkg::brp_addr_t A_ADDR,
	input wire brp_pkg::brp_data_t A_WDATA,
	output brp_pkg::brp_data_t A_RDATA,
	// port b
	input wire logic B_CE,
	input wire logic B_WE,
	input wire brp_pkg::brp_addr_t B_ADDR,
	input wire brp_pkg::brp_data_t B_WDATA,
	output brp_pkg::brp_data_t B_RDATA
);
	import brp_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_mux;
	logic addr_ok;
	logic refuse;
	logic apb_done;
	logic load_fire;
	logic [2:0] ctrl_q;
	logic [5:0] cfg_q [2];
	brp_widx_t load_addr_q;
	logic [31:0] load_lo_q;
	brp_pmode_t pmode;
	brp_wsel_t wsel [2];
	brp_wmode_t wmode [2];
	logic cfg_err;
	logic [1:0] p_ce;
	logic [1:0] p_we;
	logic [1:0] p_rst;
	logic [1:0] en;
	logic [1:0] wr_allow;
	brp_addr_t p_addr [2];
	brp_data_t p_wdata [2];
	logic [1:0] req_q;
	logic [1:0] wr_q;
	brp_addr_t addr_q [2];
	brp_data_t wdata_q [2];
	brp_data_t mem_q [0:255];
	brp_widx_t widx [2];
	brp_off_t woff [2];
	brp_data_t rd_word [2];
	brp_data_t rd_data [2];
	brp_data_t wmask [2];
	brp_data_t wsh [2];
	brp_data_t new_word [2];
	logic [1:0] wfire;
	logic collide;

	// pin gathering into port arrays
	assign p_ce = {B_CE, A_CE};
	assign p_we = {B_WE, A_WE};
	assign p_rst = {PORT_B_OUTPUT_RESET, PORT_A_OUTPUT_RESET};
	assign p_addr[0] = A_ADDR;
	assign p_addr[1] = B_ADDR;
	assign p_wdata[0] = A_WDATA;
	assign p_wdata[1] = B_WDATA;

	// ----------------------------------------
	// apb slave, one wait state
	// ----------------------------------------
	assign apb_done = PSEL & PENABLE & pready_q;
	assign load_fire = apb_done & PWRITE & (PADDR == `BRP_ADDR_LOAD_HI) & ~ctrl_q[`BRP_CTRL_WREN];
	assign refuse = PWRITE & (PADDR == `BRP_ADDR_LOAD_HI) & ctrl_q[`BRP_CTRL_WREN];

	// read decode and unmapped detection
	always_comb begin
		rd_mux = 32'h00000000;
		addr_ok = 1'b1;
		case (PADDR)
			`BRP_ADDR_CTRL: rd_mux[2:0] = ctrl_q;
			`BRP_ADDR_CFG_A: rd_mux[5:0] = cfg_q[0];
			`BRP_ADDR_CFG_B: rd_mux[5:0] = cfg_q[1];
			`BRP_ADDR_STATUS: begin
				rd_mux[`BRP_ST_CFG_ERR] = cfg_err;
				rd_mux[`BRP_ST_A_CLR] = PORT_A_OUTPUT_RESET;
				rd_mux[`BRP_ST_B_CLR] = PORT_B_OUTPUT_RESET;
				rd_mux[`BRP_ST_CHIP_CLR] = ~CHIP_WIDE_RESET_N;
			end
			`BRP_ADDR_LOAD_ADDR: rd_mux[7:0] = load_addr_q;
			`BRP_ADDR_LOAD_LO: rd_mux = load_lo_q;
			`BRP_ADDR_LOAD_HI: rd_mux = 32'h00000000;
			default: addr_ok = 1'b0;
		endcase
	end

	// handshake, read data and error flag
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h00000000;
		end else begin
			pready_q <= PSEL & PENABLE & ~pready_q;
			if (PSEL & PENABLE & ~pready_q) begin
				prdata_q <= PWRITE ? 32'h00000000 : rd_mux;
				pslverr_q <= ~addr_ok | refuse;
			end
		end
	end
	assign PREADY = pready_q;
	assign PSLVERR = pslverr_q;
	assign PRDATA = prdata_q;

	// control, port configuration and preload pointer
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ctrl_q <= `BRP_CTRL_RST;
			cfg_q[0] <= `BRP_CFG_RST;
			cfg_q[1] <= `BRP_CFG_RST;
			load_addr_q <= 8'h00;
			load_lo_q <= 32'h00000000;
		end else if (apb_done & PWRITE) begin
			case (PADDR)
				`BRP_ADDR_CTRL: ctrl_q <= PWDATA[2:0];
				`BRP_ADDR_CFG_A: cfg_q[0] <= PWDATA[5:0];
				`BRP_ADDR_CFG_B: cfg_q[1] <= PWDATA[5:0];
				`BRP_ADDR_LOAD_ADDR: load_addr_q <= PWDATA[7:0];
				`BRP_ADDR_LOAD_LO: load_lo_q <= PWDATA;
				default: ;
			endcase
			if (load_fire) begin
				load_addr_q <= load_addr_q + 8'h01;
			end
		end
	end

	// ----------------------------------------
	// configuration check
	// ----------------------------------------
	assign pmode = brp_pmode_t'(ctrl_q[`BRP_CTRL_MODE]);

	// illegal widths, modes and read-before-write widths
	always_comb begin
		cfg_err = (pmode == BRP_MODE_RSVD);
		for (int g = 0; g < 2; g++) begin
			wsel[g] = cfg_q[g][`BRP_CFG_WSEL];
			wmode[g] = brp_wmode_t'(cfg_q[g][`BRP_CFG_WMODE]);
			cfg_err = cfg_err | (wsel[g] > `BRP_WSEL_X36) | (wmode[g] == BRP_WM_RSVD);
			cfg_err = cfg_err | ((wmode[g] == BRP_WM_RBW) & (wsel[g] < `BRP_WSEL_X9));
		end
		cfg_err = cfg_err | ((pmode == BRP_TRUE_DUAL) & ((wsel[0] == `BRP_WSEL_X36) | (wsel[1] == `BRP_WSEL_X36)));
	end

	// port b used in every mode but single, writes only in true dual
	assign en = {pmode != BRP_SINGLE, 1'b1};
	assign wr_allow[0] = ctrl_q[`BRP_CTRL_WREN] & ~cfg_err;
	assign wr_allow[1] = ctrl_q[`BRP_CTRL_WREN] & ~cfg_err & (pmode == BRP_TRUE_DUAL);

	// ----------------------------------------
	// input registers
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			req_q <= 2'b00;
			wr_q <= 2'b00;
		end else begin
			for (int g = 0; g < 2; g++) begin
				req_q[g] <= p_ce[g] & en[g];
				if (p_ce[g]) begin
					wr_q[g] <= p_we[g] & wr_allow[g];
				end else begin
					wr_q[g] <= 1'b0;
				end
			end
		end
	end

	// address and data capture on enabled cycles only
	always_ff @(posedge CLOCK) begin
		for (int g = 0; g < 2; g++) begin
			if (p_ce[g]) begin
				addr_q[g] <= p_addr[g];
				wdata_q[g] <= p_wdata[g];
			end
		end
	end

	// ----------------------------------------
	// array access
	// ----------------------------------------
	// word select, lane shift and merge of the two ports
	always_comb begin
		for (int g = 0; g < 2; g++) begin
			widx[g] = brp_word(wsel[g], addr_q[g]);
			woff[g] = brp_off(wsel[g], addr_q[g]);
			rd_word[g] = mem_q[widx[g]];
			rd_data[g] = (rd_word[g] >> woff[g]) & brp_mask(wsel[g]);
			wmask[g] = brp_mask(wsel[g]) << woff[g];
			wsh[g] = (wdata_q[g] & brp_mask(wsel[g])) << woff[g];
			wfire[g] = req_q[g] & wr_q[g];
		end
		collide = wfire[0] & (widx[0] == widx[1]);
		new_word[0] = (rd_word[0] & ~wmask[0]) | wsh[0];
		new_word[1] = ((collide ? new_word[0] : rd_word[1]) & ~wmask[1]) | wsh[1];
	end

	// array writes; preload only while user writes are off
	always_ff @(posedge CLOCK) begin
		if (wfire[0]) begin
			mem_q[widx[0]] <= new_word[0];
		end
		if (wfire[1]) begin
			mem_q[widx[1]] <= new_word[1];
		end
		if (load_fire) begin
			mem_q[load_addr_q] <= {PWDATA[`BRP_LOAD_HI], load_lo_q};
		end
	end

	// ----------------------------------------
	// port read paths
	// ----------------------------------------
	brp_port_if pif [2] ();
	for (genvar g = 0; g < 2; g++) begin : g_port
		assign pif[g].req = req_q[g];
		assign pif[g].wr = wr_q[g];
		assign pif[g].ce = p_ce[g];
		assign pif[g].oreg = cfg_q[g][`BRP_CFG_OREG];
		assign pif[g].clr = p_rst[g] | ~CHIP_WIDE_RESET_N;
		assign pif[g].wmode = wmode[g];
		assign pif[g].wdata = wdata_q[g] & brp_mask(wsel[g]);
		assign pif[g].rdarr = rd_data[g];
		brp_port_out u_out (
			.clk(CLOCK),
			.rst(RST),
			.pif(pif[g])
		);
	end
	assign A_RDATA = pif[0].dout;
	assign B_RDATA = pif[1].dout;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_input_capture: assert property (@(posedge CLOCK) disable iff (RST)
		A_CE |=> req_q[0] && addr_q[0] == $past(A_ADDR) && wdata_q[0] == $past(A_WDATA))
		else $error("port a inputs not captured");
	a_port_reset: assert property (@(posedge CLOCK) disable iff (RST)
		PORT_A_OUTPUT_RESET |-> A_RDATA == 36'h000000000) else $error("port a output not cleared");
	a_port_isolated: assert property (@(posedge CLOCK) disable iff (RST)
		$rose(PORT_A_OUTPUT_RESET) && !PORT_B_OUTPUT_RESET && CHIP_WIDE_RESET_N && !B_CE && !req_q[1]
		|=> $stable(B_RDATA)) else $error("port a reset touched port b");
	a_chip_reset: assert property (@(posedge CLOCK) disable iff (RST)
		!CHIP_WIDE_RESET_N |-> A_RDATA == 36'h000000000 && B_RDATA == 36'h000000000)
		else $error("chip-wide reset missed a port");
	a_ce_low_hold: assert property (@(posedge CLOCK)
		disable iff (RST || PORT_A_OUTPUT_RESET || !CHIP_WIDE_RESET_N)
		(!A_CE) [*2] |=> $stable(A_RDATA)) else $error("port a output moved while disabled");
	a_rom_locked: assert property (@(posedge CLOCK) disable iff (RST)
		!ctrl_q[`BRP_CTRL_WREN] && A_CE && A_WE |=> !wr_q[0]) else $error("write taken in rom use");
	a_dual_width: assert property (@(posedge CLOCK) disable iff (RST)
		pmode == BRP_TRUE_DUAL && wsel[1] == `BRP_WSEL_X36 && B_CE && B_WE |=> !wr_q[1])
		else $error("x36 write in true dual port");
	a_apb_wait: assert property (@(posedge CLOCK) disable iff (RST)
		PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY) else $error("apb answer not one wait state");
	c_preload: cover property (@(posedge CLOCK) load_fire ##1 load_fire);
	c_collide: cover property (@(posedge CLOCK) wfire[0] && wfire[1] && collide);
endmodule : brp_ram_ctl

// ---- verification/brp_fabric_model.sv ----
// user fabric model that drives one ram port
`timescale 1ns/100ps
module brp_fabric_model (
	// clock
	input wire logic clk,
	// port request
	output logic ce,
	output logic we,
	output brp_pkg::brp_addr_t addr,
	output brp_pkg::brp_data_t wdata
);
	import brp_pkg::*;
	// idle with the enable low from time zero
	initial begin
		ce = 1'b0;
		we = 1'b0;
		addr = '0;
		wdata = '0;
	end
	// request held for n+1 edges, then released with inverted qualifiers
	task automatic access(input logic w, input brp_addr_t a, input brp_data_t d, input int n);
		@(posedge clk);
		ce <= 1'b1;
		we <= w;
		addr <= a;
		wdata <= d;
		repeat (n + 1) @(posedge clk);
		ce <= 1'b0;
		we <= ~w;
		addr <= ~a;
		wdata <= ~d;
		@(posedge clk);
		#1;
	endtask : access
endmodule : brp_fabric_model

// ---- verification/test_block_ram_port_control.sv ----
// self-checking bench of the block ram port control
`timescale 1ns/100ps
`include "brp_params.svh"
module test_block_ram_port_control;
	import brp_pkg::*;
	logic CLOCK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
	logic [11:0] PADDR;
	logic [31:0] PWDATA, PRDATA, rd;
	logic PORT_A_OUTPUT_RESET, PORT_B_OUTPUT_RESET, CHIP_WIDE_RESET_N, er;
	logic A_CE, A_WE, B_CE, B_WE;
	brp_addr_t A_ADDR, B_ADDR;
	brp_data_t A_WDATA, B_WDATA, A_RDATA, B_RDATA;
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int wd[5] = '{1, 2, 4, 9, 18};

	// ----------------------------------------
	// design and fabric models
	// ----------------------------------------
	brp_ram_ctl dut_u (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.PORT_A_OUTPUT_RESET(PORT_A_OUTPUT_RESET), .PORT_B_OUTPUT_RESET(PORT_B_OUTPUT_RESET),
		.CHIP_WIDE_RESET_N(CHIP_WIDE_RESET_N), .A_CE(A_CE), .A_WE(A_WE), .A_ADDR(A_ADDR),
		.A_WDATA(A_WDATA), .A_RDATA(A_RDATA), .B_CE(B_CE), .B_WE(B_WE), .B_ADDR(B_ADDR),
		.B_WDATA(B_WDATA), .B_RDATA(B_RDATA));
	brp_fabric_model fab_a (.clk(CLOCK), .ce(A_CE), .we(A_WE), .addr(A_ADDR), .wdata(A_WDATA));
	brp_fabric_model fab_b (.clk(CLOCK), .ce(B_CE), .we(B_WE), .addr(B_ADDR), .wdata(B_WDATA));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// clock of 10 ns, never stopped, so it is steady around every reset edge
	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end
	// hang guard
	always @(posedge CLOCK) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			$display("BAD timeout expected done seen hang");
			finish_test();
		end
	end
	function automatic brp_data_t pword(input int i);
		pword = 36'h9a5c30f1e ^ {9{i[3:0]}};
	endfunction : pword
	// x18 view of the preloaded words
	function automatic brp_data_t half(input int a);
		half = (pword(a / 2) >> (18 * (a % 2))) & 36'h3ffff;
	endfunction : half
	task automatic chk(input string nm, input brp_data_t e, input brp_data_t g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one apb transfer, held until pready; only the hang guard ends the wait
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		do begin
			@(posedge CLOCK);
		end while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb
	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		chk(nm, {4'h0, e}, {4'h0, rd});
		chk("pslverr", {35'h0, ee}, {35'h0, er});
	endtask : rdc

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		rdc("ctrl", `BRP_ADDR_CTRL, 32'h3, 1'b0);
		rdc("cfg_a", `BRP_ADDR_CFG_A, 32'h4, 1'b0);
		rdc("unmapped", 12'h01c, 32'h0, 1'b1);
		apb(1'b1, `BRP_ADDR_LOAD_HI, 32'h0);
		chk("load refused", 36'h1, {35'h0, er});
	endtask : t_regs
	// preload with writes off, then a port write must be dropped
	task automatic t_preload();
		apb(1'b1, `BRP_ADDR_CTRL, 32'h2);
		apb(1'b1, `BRP_ADDR_LOAD_ADDR, 32'h0);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `BRP_ADDR_LOAD_LO, 32'(pword(i)));
			apb(1'b1, `BRP_ADDR_LOAD_HI, 32'(pword(i) >> 32));
		end
		fab_a.access(1'b1, 13'h1, 36'h12345, 0);
		fab_a.access(1'b0, 13'h1, 36'h0, 0);
		chk("rom", half(1), A_RDATA);
	endtask : t_preload
	task automatic t_widths();
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, `BRP_ADDR_CFG_A, i);
			fab_a.access(1'b0, 13'h1, 36'h0, 0);
			chk("width", (pword(0) >> wd[i]) & ((36'h1 << wd[i]) - 36'h1), A_RDATA);
		end
		apb(1'b1, `BRP_ADDR_CFG_A, 32'h4);
		fab_b.access(1'b0, 13'h0, 36'h0, 0);
		chk("b read", half(0), B_RDATA);
	endtask : t_widths
	// normal, write-through and read-before-write on port a
	task automatic t_modes();
		brp_data_t dw;
		brp_data_t ex[3];
		apb(1'b1, `BRP_ADDR_CTRL, 32'h3);
		for (int m = 0; m < 3; m++) begin
			dw = 36'h2a5a5 + m;
			ex = '{half(0), dw, half(4 + m)};
			apb(1'b1, `BRP_ADDR_CFG_A, (m << 3) | 4);
			fab_a.access(1'b0, 13'h0, 36'h0, 0);
			fab_a.access(1'b1, 13'(4 + m), dw, 0);
			chk("write out", ex[m], A_RDATA);
			repeat (3) @(posedge CLOCK);
			#1;
			chk("ce low hold", ex[m], A_RDATA);
			fab_a.access(1'b0, 13'(4 + m), 36'h0, 0);
			chk("read back", dw, A_RDATA);
		end
		apb(1'b1, `BRP_ADDR_CFG_A, 32'h12);
		rdc("status", `BRP_ADDR_STATUS, 32'h1, 1'b0);
		apb(1'b1, `BRP_ADDR_CFG_A, 32'h4);
		// x36 on port b is illegal in true dual, so its write must drop
		apb(1'b1, `BRP_ADDR_CFG_B, 32'h5);
		fab_b.access(1'b1, 13'h0, 36'hfffffffff, 0);
		rdc("x36 dual", `BRP_ADDR_STATUS, 32'h1, 1'b0);
		apb(1'b1, `BRP_ADDR_CFG_B, 32'h4);
	endtask : t_modes
	// pseudo dual: port b writes dropped; single: port b ignored
	task automatic t_pmodes();
		apb(1'b1, `BRP_ADDR_CTRL, 32'h5);
		fab_b.access(1'b1, 13'h0, 36'h15a5a, 0);
		fab_b.access(1'b0, 13'h0, 36'h0, 0);
		chk("pseudo b write", half(0), B_RDATA);
		apb(1'b1, `BRP_ADDR_CTRL, 32'h1);
		fab_b.access(1'b0, 13'h1, 36'h0, 0);
		chk("single b idle", half(0), B_RDATA);
		apb(1'b1, `BRP_ADDR_CTRL, 32'h3);
	endtask : t_pmodes
	task automatic t_oreg();
		apb(1'b1, `BRP_ADDR_CFG_A, 32'h24);
		// output register advances only on enabled edges: enable held two extra edges
		fab_a.access(1'b0, 13'h0, 36'h0, 2);
		chk("oreg", half(0), A_RDATA);
		fab_a.access(1'b0, 13'h1, 36'h0, 0);
		chk("oreg stall", half(0), A_RDATA);
		fab_a.access(1'b0, 13'h1, 36'h0, 1);
		chk("oreg next", half(1), A_RDATA);
		apb(1'b1, `BRP_ADDR_CFG_A, 32'h4);
	endtask : t_oreg
	// asynchronous output resets, enables already low
	task automatic t_resets();
		fab_a.access(1'b0, 13'h0, 36'h0, 0);
		fab_b.access(1'b0, 13'h1, 36'h0, 0);
		@(posedge CLOCK);
		PORT_A_OUTPUT_RESET <= 1'b1;
		#3;
		chk("a reset", 36'h0, A_RDATA);
		chk("b kept", half(1), B_RDATA);
		rdc("status a", `BRP_ADDR_STATUS, 32'h2, 1'b0);
		PORT_A_OUTPUT_RESET <= 1'b0;
		repeat (2) @(posedge CLOCK);
		CHIP_WIDE_RESET_N <= 1'b0;
		#3;
		chk("chip a", 36'h0, A_RDATA);
		chk("chip b", 36'h0, B_RDATA);
		rdc("status chip", `BRP_ADDR_STATUS, 32'h8, 1'b0);
		CHIP_WIDE_RESET_N <= 1'b1;
		repeat (2) @(posedge CLOCK);
		fab_a.access(1'b0, 13'h0, 36'h0, 0);
		chk("after reset", half(0), A_RDATA);
	endtask : t_resets

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		RST = 1'b1;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 12'h000;
		PWDATA = 32'h0;
		PORT_A_OUTPUT_RESET = 1'b0;
		PORT_B_OUTPUT_RESET = 1'b0;
		CHIP_WIDE_RESET_N = 1'b1;
		repeat (16) @(posedge CLOCK);
		RST <= 1'b0;
		t_regs();
		t_preload();
		t_widths();
		t_modes();
		t_pmodes();
		t_oreg();
		t_resets();
		fab_b.access(1'b0, 13'h1, 36'h0, 0);
		chk("b before reset", half(1), B_RDATA);
		@(posedge CLOCK);
		PORT_B_OUTPUT_RESET <= 1'b1;
		#3;
		chk("b reset", 36'h0, B_RDATA);
		chk("a kept", half(0), A_RDATA);
		PORT_B_OUTPUT_RESET <= 1'b0;
		finish_test();
	end
endmodule : test_block_ram_port_control
